// >>> smp_ctrl.sv
module smp_ctrl import smp_pkg::*; #(
  parameter int unsigned NUM_CS = 8
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic req_write_i,
  input wire logic [$clog2(NUM_CS)-1:0] req_cs_i,
  input wire logic [25:0] req_addr_i,
  input wire logic [3:0] req_be_i,
  input wire logic [31:0] req_wdata_i,
  output logic done_o,
  output logic [31:0] rdata_o,
  input wire logic slow_clock_i,
  input wire logic periph_access_i,
  output logic [25:0] mem_addr_o,
  output logic [NUM_CS-1:0] chip_select_n_o,
  output logic read_strobe_n_o,
  output logic write_strobe_n_o,
  output logic [3:0] byte_lane_n_o,
  output logic [31:0] mem_wdata_o,
  output logic mem_data_oe_n_o,
  input wire logic [31:0] mem_rdata_i
);

  localparam int unsigned CSW = $clog2(NUM_CS);

  // ==========================================================================
  // Parameter check
  if (NUM_CS < 2 || NUM_CS > SMP_MAX_CS) begin : g_bad_cs
    $error("NUM_CS must lie between 2 and 8");
  end

  typedef struct packed {
    logic [NUM_CS-1:0][3:0][31:0] shadow;
    logic [NUM_CS-1:0][3:0][31:0] active;
    smp_state_t st;
    logic [9:0] cnt;
    logic [9:0] len;
    logic [9:0] stb_s;
    logic [9:0] stb_p;
    logic [9:0] cs_s;
    logic [9:0] cs_p;
    logic is_wr;
    logic slow;
    logic byte_access_type;
    logic rd_by_stb;
    logic [CSW-1:0] cur_cs;
    logic [25:0] cur_addr;
    logic [3:0] cur_be;
    logic [31:0] cur_wdata;
    logic page_vld;
    logic [CSW-1:0] page_cs;
    logic [25:0] page_tag;
    logic [31:0] rdata;
    logic [31:0] cap;
    logic done;
    logic [31:0] readdata;
    logic rd_valid;
    logic [NUM_CS-1:0] cs_n;
    logic rd_n;
    logic wr_n;
    logic [3:0] lane_n;
    logic oe_n;
  } smp_regs_t;

  smp_regs_t s_r;
  smp_regs_t s_nxt;

  // Strobe is low while setup <= c < setup + pulse
  function automatic logic in_pulse(input logic [9:0] c, input logic [9:0] st, input logic [9:0] p);
    return (c >= st) && ({1'b0, c} < ({1'b0, st} + {1'b0, p}));
  endfunction

  // Last cycle of a pulse
  function automatic logic pulse_end(input logic [9:0] c, input logic [9:0] st, input logic [9:0] p);
    return ({1'b0, c} + 11'h001) == ({1'b0, st} + {1'b0, p});
  endfunction

  // Reset value of the register file
  function automatic smp_regs_t reset_val();
    smp_regs_t r;
    r = '0;
    for (int c = 0; c < NUM_CS; c++) begin
      r.shadow[c][SMP_IDX_SETUP] = SMP_RST_SETUP;
      r.shadow[c][SMP_IDX_PULSE] = SMP_RST_PULSE;
      r.shadow[c][SMP_IDX_CYCLE] = SMP_RST_CYCLE;
      r.shadow[c][SMP_IDX_MODE] = SMP_RST_MODE;
    end
    r.active = r.shadow;
    r.st = SMP_IDLE;
    r.cs_n = '1;
    r.rd_n = 1'b1;
    r.wr_n = 1'b1;
    r.lane_n = 4'hF;
    r.oe_n = 1'b1;
    return r;
  endfunction

  // ==========================================================================
  // Decode of the live request against the committed configuration
  logic [31:0] req_mode;
  logic [31:0] req_pulse;
  logic [25:0] req_mask;
  logic req_page_ok;
  logic req_hit;
  logic accept;

  always_comb begin
    req_mode = s_r.active[req_cs_i][SMP_IDX_MODE];
    req_pulse = s_r.active[req_cs_i][SMP_IDX_PULSE];
    req_mask = smp_page_mask(req_mode[SMP_F_PAGE_SIZE +: 2], req_mode[SMP_F_DBW +: 2]);
    // Burst read only on page-enabled chip selects at full rate
    req_page_ok = !req_write_i && req_mode[SMP_F_PAGE_EN] && !slow_clock_i;
    // Same chip select and page bits as the open page
    req_hit = s_r.page_vld && (req_cs_i == s_r.page_cs) &&
              ((req_addr_i & req_mask) == s_r.page_tag);
    accept = req_valid_i && ((s_r.st == SMP_IDLE) ||
             ((s_r.st == SMP_OPEN) && req_page_ok && (req_cs_i == s_r.page_cs) && !periph_access_i));
  end

  assign req_ready_o = (s_r.st == SMP_IDLE) ||
                       ((s_r.st == SMP_OPEN) && req_page_ok && (req_cs_i == s_r.page_cs) && !periph_access_i);

  // ==========================================================================
  // Next state
  logic [CSW:0] bus_cs;
  logic [1:0] bus_reg;
  logic bus_mapped;
  logic stb_lo;
  logic cs_lo;

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.rd_valid = 1'b0;
    bus_cs = avs_address_i[4 +: CSW+1];
    bus_reg = avs_address_i[3:2];
    bus_mapped = (avs_address_i[7:4] < 4'(NUM_CS));
    stb_lo = 1'b0;
    cs_lo = 1'b0;

    // Register writes, byte lanes honoured, reserved bits kept zero
    if (avs_write_i && bus_mapped) begin
      for (int b = 0; b < 4; b++) begin
        if (avs_byteenable_i[b]) begin
          s_nxt.shadow[bus_cs[CSW-1:0]][bus_reg][8*b +: 8] = avs_writedata_i[8*b +: 8];
        end
      end
      case (bus_reg)
        SMP_IDX_SETUP: s_nxt.shadow[bus_cs[CSW-1:0]][bus_reg] &= SMP_MSK_SETUP;
        SMP_IDX_PULSE: s_nxt.shadow[bus_cs[CSW-1:0]][bus_reg] &= SMP_MSK_PULSE;
        SMP_IDX_CYCLE: s_nxt.shadow[bus_cs[CSW-1:0]][bus_reg] &= SMP_MSK_CYCLE;
        default: s_nxt.shadow[bus_cs[CSW-1:0]][bus_reg] &= SMP_MSK_MODE;
      endcase
      // A mode write commits every staged register
      if (bus_reg == SMP_IDX_MODE) begin
        s_nxt.active = s_nxt.shadow;
      end
    end

    // Register reads: one wait cycle, then registered data
    if (avs_read_i && !s_r.rd_valid) begin
      s_nxt.rd_valid = 1'b1;
      s_nxt.readdata = '0;
      if (bus_mapped) begin
        s_nxt.readdata = s_r.shadow[bus_cs[CSW-1:0]][bus_reg];
      end else if (avs_address_i == SMP_OFS_STATUS) begin
        s_nxt.readdata[SMP_S_BUSY] = (s_r.st != SMP_IDLE);
        s_nxt.readdata[SMP_S_PAGE_OPEN] = s_r.page_vld;
        s_nxt.readdata[SMP_S_SLOW] = s_r.slow;
        s_nxt.readdata[SMP_S_PAGE_CS +: CSW] = s_r.page_cs;
      end
    end

    // Transfer engine
    case (s_r.st)
      SMP_IDLE: begin
        if (accept) begin
          s_nxt.cnt = '0;
          s_nxt.is_wr = req_write_i;
          s_nxt.cur_cs = req_cs_i;
          s_nxt.cur_addr = req_addr_i;
          s_nxt.cur_be = req_be_i;
          s_nxt.cur_wdata = req_wdata_i;
          s_nxt.byte_access_type = req_mode[SMP_F_BYTE_ACC];
          s_nxt.slow = slow_clock_i;
          if (req_page_ok) begin
            // Page just opened: first access uses the chip select read pulse
            s_nxt.st = SMP_PAGE;
            s_nxt.len = smp_pulse_len(req_pulse[SMP_F_CS_RD +: 7]);
            s_nxt.page_vld = 1'b1;
            s_nxt.page_cs = req_cs_i;
            s_nxt.page_tag = req_addr_i & req_mask;
          end else if (slow_clock_i) begin
            s_nxt.st = SMP_STD;
            s_nxt.rd_by_stb = 1'b0;
            s_nxt.stb_s = req_write_i ? SMP_SLOW_WR_SETUP : SMP_SLOW_RD_SETUP;
            s_nxt.stb_p = req_write_i ? SMP_SLOW_WR_PULSE : SMP_SLOW_RD_PULSE;
            s_nxt.cs_s = req_write_i ? SMP_SLOW_CS_WR_SETUP : SMP_SLOW_CS_RD_SETUP;
            s_nxt.cs_p = req_write_i ? SMP_SLOW_CS_WR_PULSE : SMP_SLOW_CS_RD_PULSE;
            s_nxt.len = req_write_i ? SMP_SLOW_WR_CYCLE : SMP_SLOW_RD_CYCLE;
          end else begin
            s_nxt.st = SMP_STD;
            s_nxt.rd_by_stb = req_mode[SMP_F_READ_MODE];
            if (req_write_i) begin
              s_nxt.stb_s = smp_setup_len(s_r.active[req_cs_i][SMP_IDX_SETUP][SMP_F_WR_STB +: 6]);
              s_nxt.cs_s = smp_setup_len(s_r.active[req_cs_i][SMP_IDX_SETUP][SMP_F_CS_WR +: 6]);
              s_nxt.stb_p = smp_pulse_len(req_pulse[SMP_F_WR_STB +: 7]);
              s_nxt.cs_p = smp_pulse_len(req_pulse[SMP_F_CS_WR +: 7]);
              s_nxt.len = smp_cycle_len(s_r.active[req_cs_i][SMP_IDX_CYCLE][SMP_F_WR_CYC +: 9]);
            end else begin
              s_nxt.stb_s = smp_setup_len(s_r.active[req_cs_i][SMP_IDX_SETUP][SMP_F_RD_STB +: 6]);
              s_nxt.cs_s = smp_setup_len(s_r.active[req_cs_i][SMP_IDX_SETUP][SMP_F_CS_RD +: 6]);
              s_nxt.stb_p = smp_pulse_len(req_pulse[SMP_F_RD_STB +: 7]);
              s_nxt.cs_p = smp_pulse_len(req_pulse[SMP_F_CS_RD +: 7]);
              s_nxt.len = smp_cycle_len(s_r.active[req_cs_i][SMP_IDX_CYCLE][SMP_F_RD_CYC +: 9]);
            end
          end
        end
      end
      SMP_STD: begin
        // Parameters were latched at the start, so a slow transfer ends slow
        if (!s_r.is_wr && (s_r.rd_by_stb ? pulse_end(s_r.cnt, s_r.stb_s, s_r.stb_p)
                                          : pulse_end(s_r.cnt, s_r.cs_s, s_r.cs_p))) begin
          s_nxt.cap = mem_rdata_i;
        end
        if (({1'b0, s_r.cnt} + 11'h001) >= {1'b0, s_r.len}) begin
          s_nxt.st = SMP_IDLE;
          s_nxt.done = 1'b1;
          // Captured word is published with done, so rdata only moves with done
          if (!s_r.is_wr) begin
            s_nxt.rdata = s_nxt.cap;
          end
        end else begin
          s_nxt.cnt = s_r.cnt + 10'h001;
        end
      end
      SMP_PAGE: begin
        // Only the pulse length counts here; setups and cycle are unused
        if (({1'b0, s_r.cnt} + 11'h001) >= {1'b0, s_r.len}) begin
          s_nxt.st = SMP_OPEN;
          s_nxt.done = 1'b1;
          s_nxt.rdata = mem_rdata_i;
        end else begin
          s_nxt.cnt = s_r.cnt + 10'h001;
        end
      end
      SMP_OPEN: begin
        if (accept) begin
          s_nxt.st = SMP_PAGE;
          s_nxt.cnt = '0;
          s_nxt.cur_addr = req_addr_i;
          s_nxt.cur_be = req_be_i;
          s_nxt.byte_access_type = req_mode[SMP_F_BYTE_ACC];
          s_nxt.slow = 1'b0;
          // Hit uses read strobe pulse, miss reopens with chip select pulse
          s_nxt.len = req_hit ? smp_pulse_len(req_pulse[SMP_F_RD_STB +: 7])
                              : smp_pulse_len(req_pulse[SMP_F_CS_RD +: 7]);
          s_nxt.page_tag = req_addr_i & req_mask;
        end else if (periph_access_i || slow_clock_i || req_valid_i) begin
          // Release the chip select; the page record goes with it
          s_nxt.st = SMP_IDLE;
          s_nxt.page_vld = 1'b0;
        end
      end
      default: begin
        s_nxt.st = SMP_IDLE;
      end
    endcase

    // Pin levels for the cycle being entered
    s_nxt.cs_n = '1;
    s_nxt.rd_n = 1'b1;
    s_nxt.wr_n = 1'b1;
    s_nxt.lane_n = 4'hF;
    s_nxt.oe_n = 1'b1;
    case (s_nxt.st)
      SMP_STD: begin
        stb_lo = in_pulse(s_nxt.cnt, s_nxt.stb_s, s_nxt.stb_p);
        cs_lo = in_pulse(s_nxt.cnt, s_nxt.cs_s, s_nxt.cs_p);
        s_nxt.cs_n[s_nxt.cur_cs] = !cs_lo;
        s_nxt.rd_n = !(stb_lo && !s_nxt.is_wr);
        s_nxt.wr_n = !(stb_lo && s_nxt.is_wr && !s_nxt.byte_access_type);
        s_nxt.oe_n = !s_nxt.is_wr;
        if (s_nxt.byte_access_type) begin
          s_nxt.lane_n = (stb_lo && s_nxt.is_wr) ? ~s_nxt.cur_be : 4'hF;
        end else begin
          s_nxt.lane_n = cs_lo ? ~s_nxt.cur_be : 4'hF;
        end
      end
      SMP_PAGE, SMP_OPEN: begin
        s_nxt.cs_n[s_nxt.cur_cs] = 1'b0;
        s_nxt.rd_n = 1'b0;
        s_nxt.lane_n = s_nxt.byte_access_type ? 4'hF : ~s_nxt.cur_be;
      end
      default: begin
        s_nxt.lane_n = 4'hF;
      end
    endcase
  end

  // ==========================================================================
  // State register
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_r <= reset_val();
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  // Register bus: data from flops, stall only in the first read cycle
  assign avs_readdata_o = s_r.readdata;
  assign avs_waitrequest_o = avs_read_i && !s_r.rd_valid;

  // Transfer handshake back to the requester
  assign done_o = s_r.done;
  assign rdata_o = s_r.rdata;

  // Memory pins, all straight from the state register
  assign mem_addr_o = s_r.cur_addr;
  assign chip_select_n_o = s_r.cs_n;
  assign read_strobe_n_o = s_r.rd_n;
  assign write_strobe_n_o = s_r.wr_n;
  assign byte_lane_n_o = s_r.lane_n;
  assign mem_wdata_o = s_r.cur_wdata;
  assign mem_data_oe_n_o = s_r.oe_n;

endmodule

// >>> smp_pkg.sv
package smp_pkg;

  // ==========================================================================
  // Register map
  localparam logic [1:0] SMP_IDX_SETUP = 2'h0;
  localparam logic [1:0] SMP_IDX_PULSE = 2'h1;
  localparam logic [1:0] SMP_IDX_CYCLE = 2'h2;
  localparam logic [1:0] SMP_IDX_MODE = 2'h3;
  localparam logic [7:0] SMP_CS_STRIDE = 8'h10;
  localparam logic [7:0] SMP_OFS_STATUS = 8'hE0;
  localparam int unsigned SMP_MAX_CS = 8;
  localparam logic [31:0] SMP_RST_SETUP = 32'h00000000;
  localparam logic [31:0] SMP_RST_PULSE = 32'h01010101;
  localparam logic [31:0] SMP_RST_CYCLE = 32'h00010001;
  localparam logic [31:0] SMP_RST_MODE = 32'h10001000;
  localparam logic [31:0] SMP_MSK_SETUP = 32'h3F3F3F3F;
  localparam logic [31:0] SMP_MSK_PULSE = 32'h7F7F7F7F;
  localparam logic [31:0] SMP_MSK_CYCLE = 32'h01FF01FF;
  localparam logic [31:0] SMP_MSK_MODE = 32'h311F3133;

  // ==========================================================================
  // Field positions
  localparam int unsigned SMP_F_WR_STB = 0;
  localparam int unsigned SMP_F_CS_WR = 8;
  localparam int unsigned SMP_F_RD_STB = 16;
  localparam int unsigned SMP_F_CS_RD = 24;
  localparam int unsigned SMP_F_WR_CYC = 0;
  localparam int unsigned SMP_F_RD_CYC = 16;
  localparam int unsigned SMP_F_READ_MODE = 0;
  localparam int unsigned SMP_F_BYTE_ACC = 8;
  localparam int unsigned SMP_F_DBW = 12;
  localparam int unsigned SMP_F_PAGE_EN = 24;
  localparam int unsigned SMP_F_PAGE_SIZE = 28;
  localparam logic [1:0] SMP_DBW_16 = 2'h1;
  localparam logic [1:0] SMP_DBW_32 = 2'h2;
  localparam int unsigned SMP_S_BUSY = 0;
  localparam int unsigned SMP_S_PAGE_OPEN = 1;
  localparam int unsigned SMP_S_SLOW = 2;
  localparam int unsigned SMP_S_PAGE_CS = 8;

  // ==========================================================================
  // Slow clock waveform, in cycles
  localparam logic [9:0] SMP_SLOW_RD_SETUP = 10'h001;
  localparam logic [9:0] SMP_SLOW_RD_PULSE = 10'h001;
  localparam logic [9:0] SMP_SLOW_CS_RD_SETUP = 10'h000;
  localparam logic [9:0] SMP_SLOW_CS_RD_PULSE = 10'h002;
  localparam logic [9:0] SMP_SLOW_RD_CYCLE = 10'h002;
  localparam logic [9:0] SMP_SLOW_WR_SETUP = 10'h001;
  localparam logic [9:0] SMP_SLOW_WR_PULSE = 10'h001;
  localparam logic [9:0] SMP_SLOW_CS_WR_SETUP = 10'h000;
  localparam logic [9:0] SMP_SLOW_CS_WR_PULSE = 10'h003;
  localparam logic [9:0] SMP_SLOW_WR_CYCLE = 10'h003;

  typedef enum logic [1:0] {SMP_IDLE, SMP_STD, SMP_PAGE, SMP_OPEN} smp_state_t;

  // Setup field: 128 * bit5 + bits 4..0
  function automatic logic [9:0] smp_setup_len(input logic [5:0] f);
    return {2'h0, f[5], 2'h0, f[4:0]};
  endfunction

  // Pulse field: 256 * bit6 + bits 5..0
  function automatic logic [9:0] smp_pulse_len(input logic [6:0] f);
    return {1'h0, f[6], 2'h0, f[5:0]};
  endfunction

  // Cycle field: 256 * bits 8..7 + bits 6..0
  function automatic logic [9:0] smp_cycle_len(input logic [8:0] f);
    return {f[8:7], 1'h0, f[6:0]};
  endfunction

  // Address bits that name the page
  function automatic logic [25:0] smp_page_mask(input logic [1:0] psize, input logic [1:0] dbw);
    logic [25:0] low;
    logic [25:0] ign;
    low = (26'h4 << psize) - 26'h1;
    ign = (dbw == SMP_DBW_32) ? 26'h3 : ((dbw == SMP_DBW_16) ? 26'h1 : 26'h0);
    return ~(low | ign);
  endfunction

endpackage

// >>> smp_mem_model.sv
module smp_mem_model (
  input wire logic ref_clk_i,
  input wire logic [7:0] cs_n_i,
  input wire logic rd_n_i,
  input wire logic [25:0] addr_i,
  output logic [31:0] data_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] last_r = 32'h0;
  // ========
  // Page memory: data follows the address, released bus toggles
  always_ff @(posedge ref_clk_i) begin
    last_r <= data_o;
  end
  // No wait line is driven back; data follows the address in the same cycle, so it always meets page mode
  assign data_o = (!rd_n_i && !(&cs_n_i)) ? {6'h2A, addr_i} : ~last_r;
endmodule

// >>> smp_sva.sv
module smp_sva import smp_pkg::*; #(
  parameter int unsigned NUM_CS = 8
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic req_valid_i,
  input wire logic req_ready_o,
  input wire logic req_write_i,
  input wire logic slow_clock_i,
  input wire logic done_o,
  input wire logic [31:0] rdata_o,
  input wire logic [NUM_CS-1:0] chip_select_n_o,
  input wire logic read_strobe_n_o,
  input wire logic write_strobe_n_o,
  input wire logic [3:0] byte_lane_n_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  // ========
  // Register bus answers
  a_read_wait: assert property ($rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("read answer not in second cycle");
  a_write_nowait: assert property (avs_write_i |-> !avs_waitrequest_o)
    else $error("write stalled");
  // ========
  // Memory pins and transfer timing
  a_one_cs: assert property ($onehot0(~chip_select_n_o))
    else $error("two chip selects low");
  a_strobe_excl: assert property (!(!read_strobe_n_o && !write_strobe_n_o))
    else $error("read and write strobes low together");
  a_idle_lanes: assert property (&chip_select_n_o |-> byte_lane_n_o == 4'hF)
    else $error("byte lanes low with no chip select");
  a_take_busy: assert property (req_valid_i && req_ready_o |=> !req_ready_o)
    else $error("ready right after take");
  a_done_pulse: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  a_slow_read: assert property (req_valid_i && req_ready_o && slow_clock_i && !req_write_i |-> ##1 !done_o ##1 !done_o ##1 done_o)
    else $error("slow read length wrong");
  a_rdata_hold: assert property ($changed(rdata_o) |-> done_o)
    else $error("read data moved without done");
endmodule

// >>> tb.sv
module tb import smp_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk_i = 1'h0;
  logic rstn_i = 1'h0;
  logic [7:0] avs_address_i = 8'h0;
  logic avs_read_i = 1'h0;
  logic avs_write_i = 1'h0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic req_valid_i = 1'h0;
  logic req_ready_o;
  logic req_write_i = 1'h0;
  logic [2:0] req_cs_i = 3'h0;
  logic [25:0] req_addr_i = 26'h0;
  logic [31:0] req_wdata_i = 32'h0;
  logic [3:0] req_be_i = 4'hF;
  logic byte_wr_sel = 1'h0;
  logic done_o;
  logic [31:0] rdata_o;
  logic slow_clock_i = 1'h0;
  logic periph_access_i = 1'h0;
  logic [25:0] mem_addr_o;
  logic [7:0] chip_select_n_o;
  logic read_strobe_n_o;
  logic write_strobe_n_o;
  logic [3:0] byte_lane_n_o;
  logic [31:0] mem_wdata_o;
  logic mem_data_oe_n_o;
  logic [31:0] mem_rdata_i;
  logic [31:0] rst[4] = '{SMP_RST_SETUP, SMP_RST_PULSE, SMP_RST_CYCLE, SMP_RST_MODE};
  int error_cnt = 0;
  int total_checks = 0;

  // ========
  // Design, far-side memory and clock
  smp_ctrl #(.NUM_CS(8)) smp_ctrl_i (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_write_i(req_write_i), .req_cs_i(req_cs_i),
    .req_addr_i(req_addr_i), .req_be_i(req_be_i), .req_wdata_i(req_wdata_i), .done_o(done_o), .rdata_o(rdata_o),
    .slow_clock_i(slow_clock_i), .periph_access_i(periph_access_i), .mem_addr_o(mem_addr_o),
    .chip_select_n_o(chip_select_n_o), .read_strobe_n_o(read_strobe_n_o), .write_strobe_n_o(write_strobe_n_o),
    .byte_lane_n_o(byte_lane_n_o), .mem_wdata_o(mem_wdata_o), .mem_data_oe_n_o(mem_data_oe_n_o),
    .mem_rdata_i(mem_rdata_i));
  smp_mem_model smp_mem_model_i (.ref_clk_i(ref_clk_i), .cs_n_i(chip_select_n_o), .rd_n_i(read_strobe_n_o),
    .addr_i(mem_addr_o), .data_o(mem_rdata_i));
  initial begin
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  // ========
  // Compare, verdict and bus tasks
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'h0);
    q = avs_readdata_o;
    avs_read_i <= 1'h0;
    avs_write_i <= 1'h0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'h0, a, 32'h0, q);
    check("reg", q, e);
  endtask
  // One memory transfer; lat counts edges from take to done
  task automatic mreq(input logic [2:0] cs, input logic [25:0] a, input logic pg, output logic [31:0] lat,
                      output logic [31:0] stb);
    logic [3:0] lanes;
    lanes = byte_wr_sel ? 4'hF : ~req_be_i;
    @(posedge ref_clk_i);
    req_valid_i <= 1'h1;
    req_cs_i <= cs;
    req_addr_i <= a;
    do @(posedge ref_clk_i); while (req_ready_o !== 1'h1);
    req_valid_i <= 1'h0;
    slow_clock_i <= 1'h0;
    lat = 0;
    stb = 0;
    do begin
      @(posedge ref_clk_i);
      lat++;
      if (stb == 0 && (read_strobe_n_o & write_strobe_n_o) === 1'h0) stb = lat;
      if (pg && chip_select_n_o[cs] === 1'h0) begin
        check("page_pins", 32'({read_strobe_n_o, byte_lane_n_o}), 32'(lanes));
      end
      if (req_write_i && chip_select_n_o[cs] === 1'h0) begin
        check("wdata", mem_wdata_o, req_wdata_i);
        check("drive", 32'(mem_data_oe_n_o), 32'h0);
      end
    end while (done_o !== 1'h1 && lat < 2000);
    if (!req_write_i) check("data", rdata_o, {6'h2A, a});
  endtask

  // ========
  // Main sequence
  initial begin
    logic [31:0] q, lat, stb;
    logic [31:0] d[3];
    logic [25:0] a, in;
    int p1, p2;
    void'($urandom(93609));
    repeat (4) @(posedge ref_clk_i);
    rstn_i <= 1'h1;
    for (int c = 0; c < 8; c++) begin
      for (int r = 0; r < 4; r++) begin
        rchk(8'(16 * c + 4 * r), rst[r]);
      end
    end
    rchk(8'hF0, 32'h0);
    // Staged random timing on chip select 5, strobe inside a long cs pulse
    d[0] = $urandom() & 32'h003F3F3F;
    d[1] = ($urandom() & 32'h003E7F7F) | 32'h7F010000;
    d[2] = 32'h01FF01FF;
    for (int r = 0; r < 3; r++) begin
      bus(1'h1, 8'(8'h50 + 4 * r), d[r], q);
      rchk(8'(8'h50 + 4 * r), d[r]);
    end
    mreq(3'h5, 26'h4, 1'h0, lat, stb);
    check("pre_commit", lat, 32'h2);
    bus(1'h1, 8'h5C, 32'h00002001, q);
    mreq(3'h5, 26'h8, 1'h0, lat, stb);
    check("cycle", lat, 32'h380);
    check("setup", stb, 32'(128 * d[0][21] + d[0][20:16] + 1));
    mreq(3'h5, 26'h8, 1'h0, lat, stb);
    check("no_page", lat, 32'h380);
    // Page reads on chip select 2 for every page size, random lanes and access type
    for (int sz = 0; sz < 4; sz++) begin
      p1 = (sz == 3) ? 1 : $urandom_range(1, 12);
      p2 = $urandom_range(2, 12);
      byte_wr_sel = 1'($urandom_range(0, 1));
      req_be_i <= 4'($urandom_range(1, 15));
      bus(1'h1, 8'h20, $urandom() & SMP_MSK_SETUP, q);
      bus(1'h1, 8'h24, {1'h0, 7'(p1), 1'h0, 7'(p2), 16'h0101}, q);
      bus(1'h1, 8'h28, $urandom() & SMP_MSK_CYCLE, q);
      d[0] = (32'(sz) << SMP_F_PAGE_SIZE) | 32'h01002000 | (32'(byte_wr_sel) << SMP_F_BYTE_ACC);
      bus(1'h1, 8'h2C, d[0] | 32'($urandom_range(0, 1)), q);
      a = 26'($urandom()) & 26'h3FFFFFC;
      in = 26'((4 << sz) - 4);
      mreq(3'h2, a, 1'h1, lat, stb);
      check("first", lat, 32'(p1 + 1));
      rchk(SMP_OFS_STATUS, 32'((2 << SMP_S_PAGE_CS) | (1 << SMP_S_PAGE_OPEN) | (1 << SMP_S_BUSY)));
      mreq(3'h2, a ^ in, 1'h1, lat, stb);
      check("hit", lat, 32'(p2 + 1));
      mreq(3'h2, a ^ (26'h4 << sz), 1'h1, lat, stb);
      check("miss", lat, 32'(p1 + 1));
      mreq(3'h3, a, 1'h0, lat, stb);
      mreq(3'h2, a ^ (26'h4 << sz), 1'h1, lat, stb);
      check("cs_break", lat, 32'(p1 + 1));
      periph_access_i <= 1'h1;
      repeat (3) @(posedge ref_clk_i);
      periph_access_i <= 1'h0;
      mreq(3'h2, a ^ (26'h4 << sz), 1'h1, lat, stb);
      check("periph", lat, 32'(p1 + 1));
    end
    // Slow clock read finished at full rate, then a write
    slow_clock_i <= 1'h1;
    mreq(3'h3, 26'h10, 1'h0, lat, stb);
    check("slow", lat, 32'h3);
    req_write_i <= 1'h1;
    req_wdata_i <= $urandom();
    mreq(3'h3, 26'h14, 1'h0, lat, stb);
    check("write", lat, 32'h2);
    check("wr_setup", stb, 32'h1);
    req_write_i <= 1'h0;
    give_verdict();
  end

  // Watchdog against a hung handshake
  initial begin
    #60us;
    error_cnt++;
    give_verdict();
  end
endmodule

bind smp_ctrl smp_sva #(.NUM_CS(NUM_CS)) smp_sva_i (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_write_i(req_write_i), .slow_clock_i(slow_clock_i),
  .done_o(done_o), .rdata_o(rdata_o), .chip_select_n_o(chip_select_n_o), .read_strobe_n_o(read_strobe_n_o),
  .write_strobe_n_o(write_strobe_n_o), .byte_lane_n_o(byte_lane_n_o));
